//--- src/davi_pkg.sv
// Constants, address map and state type for the delta angle and
// delta velocity integrator.
// Assumes a single 250 MHz clock shared by every user of this package.
// Behaviour
// R1 - Velocity is halved trapezoid sum of acceleration
// R2 - Samples per result equal decimation setting plus one
// R3 - Internal sample rate runs at 2000 SPS
// R4 - Result is 32-bit, split high/low words
// R5 - Angle high word two's complement, range over 2^15
// R6 - Velocity high word: 400 m/s over 2^15
// R7 - Velocity low word holds extra resolution bits
// R8 - Y angle words at 0x28 and 0x2A
// R9 - Z angle words at 0x2C and 0x2E
// R10 - X velocity words at 0x30 and 0x32
// R11 - Y velocity words at 0x34 and 0x36
// R12 - 16-bit limits are 0x7FFF and 0x8000
// R13 - 32-bit limits are 0x7FFFFFFF and 0x80000000
// R14 - Host rescales by 2000 over measured rate
// R15 - Angle uses same trapezoid sum on gyro rate
// R16 - Angle full range is plus/minus 2160 degrees
// R17 - Both words of every axis update together
package davi_pkg;

    // Timing of the internal sample clock
    localparam int unsigned CLK_HZ         = 250_000_000;
    localparam int unsigned SAMPLE_SPS     = 2000;
    localparam int unsigned SAMPLE_DIV_CYC = CLK_HZ / SAMPLE_SPS;

    // Widths and counts
    localparam int ADDR_W = 7;
    localparam int WORD_W = 16;
    localparam int RES_W  = 32;
    localparam int DEC_W  = 16;
    localparam int NUM_CH = 4;
    localparam int IDX_W  = 3;

    // Register byte addresses, low word then high word per axis
    localparam logic [ADDR_W-1:0] ADDR_Y_ANG_LO = 7'h28;
    localparam logic [ADDR_W-1:0] ADDR_Y_ANG_HI = 7'h2A;
    localparam logic [ADDR_W-1:0] ADDR_Z_ANG_LO = 7'h2C;
    localparam logic [ADDR_W-1:0] ADDR_Z_ANG_HI = 7'h2E;
    localparam logic [ADDR_W-1:0] ADDR_X_SPD_LO = 7'h30;
    localparam logic [ADDR_W-1:0] ADDR_X_SPD_HI = 7'h32;
    localparam logic [ADDR_W-1:0] ADDR_Y_SPD_LO = 7'h34;
    localparam logic [ADDR_W-1:0] ADDR_Y_SPD_HI = 7'h36;
    // Bytes covered by the eight words, counted from the first
    localparam logic [ADDR_W-1:0] BANK_SPAN     = 7'h10;

    // Result limits and reset contents
    localparam logic [RES_W-1:0]  RES_MAX    = 32'h7FFFFFFF;
    localparam logic [RES_W-1:0]  RES_MIN    = 32'h80000000;
    localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

    // The one-half of the trapezoid; the 1/fs part is the input scale
    localparam int SCALE_SHIFT = 1;

    // Integrator sequencing, Gray coded along prime -> run -> publish
    typedef enum logic [1:0] {
        ST_PRIME = 2'b00,
        ST_RUN   = 2'b01,
        ST_PUB   = 2'b11
    } davi_state_t;

endpackage

//--- src/davi_result_bank.sv
// Result word bank: eight 16-bit read-only result words.
// Assumes the integrator loads all words in one cycle and that reads
// come from the serial register unit on the same clock.
`timescale 1ns/100ps
module davi_result_bank #(
    parameter int DEPTH  = 8,
    parameter int WORD_W = 16,
    parameter int IDX_W  = 3
) (
    // Clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    resetn,
    // Parallel load of every word at once
    input  wire logic                    ld_en,
    input  wire logic [DEPTH*WORD_W-1:0] ld_data,
    // Read request and registered answer
    input  wire logic                    rd_en,
    input  wire logic                    rd_hit,
    input  wire logic [IDX_W-1:0]        rd_idx,
    output logic      [WORD_W-1:0]       rd_data
);

    // Stored words; no documented default, cleared for determinism
    logic [WORD_W-1:0] mem_r [DEPTH];
    // Registered read data
    logic [WORD_W-1:0] rd_data_r;

    // One load strobe for all words so no axis is ever split
    genvar i;
    for (i = 0; i < DEPTH; i++) begin : g_word
        always_ff @(posedge ref_clk) begin
            if (!resetn) begin
                mem_r[i] <= davi_pkg::WORD_RESET;
            end else if (ld_en) begin
                mem_r[i] <= ld_data[i*WORD_W +: WORD_W]; // R17
            end
        end
    end

    // Read returns the pre-load word on a same-cycle collision;
    // unmapped addresses read as zero
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rd_data_r <= davi_pkg::WORD_RESET;
        end else if (rd_en) begin
            rd_data_r <= rd_hit ? mem_r[rd_idx] : davi_pkg::WORD_RESET;
        end
    end

    assign rd_data = rd_data_r;

endmodule

//--- src/davi_integrator.sv
// Delta angle (y, z gyro) and delta velocity (x, y accel) integrators
// with their eight read-only result words.
// Assumes samples arrive from the sensor chain on ref_clk, valid on
// each sample tick, and reads come from the serial register unit.
`timescale 1ns/100ps
module davi_integrator #(
    parameter int          SAMPLE_W   = 24,
    parameter int          DEC_W      = davi_pkg::DEC_W,
    parameter int unsigned SAMPLE_DIV = davi_pkg::SAMPLE_DIV_CYC
) (
    // Clock and reset
    input  wire logic                       ref_clk,
    input  wire logic                       resetn,
    // Sample timing and decimation, from the configuration unit
    input  wire logic                       ext_sample_sel,
    input  wire logic                       ext_sample_tick,
    input  wire logic [DEC_W-1:0]           decimation_setting,
    // Sensor samples, two's complement, held between ticks
    input  wire logic signed [SAMPLE_W-1:0] gyro_y_rate,
    input  wire logic signed [SAMPLE_W-1:0] gyro_z_rate,
    input  wire logic signed [SAMPLE_W-1:0] accel_x,
    input  wire logic signed [SAMPLE_W-1:0] accel_y,
    // Register read port
    input  wire logic                       rd_en,
    input  wire logic [davi_pkg::ADDR_W-1:0] rd_addr,
    output logic                            rd_valid,
    output logic [davi_pkg::WORD_W-1:0]     rd_data,
    // New results published, toward the data-ready unit
    output logic                            result_update
);

    localparam int NUM_CH = davi_pkg::NUM_CH;
    localparam int WORD_W = davi_pkg::WORD_W;
    localparam int RES_W  = davi_pkg::RES_W;
    // Sum of up to 2^DEC_W pairs of samples never overflows this
    localparam int ACC_W  = SAMPLE_W + DEC_W + 2;
    localparam int DIV_W  = $clog2(SAMPLE_DIV);

    // Channel order: y angle, z angle, x velocity, y velocity
    logic signed [SAMPLE_W-1:0] smp [NUM_CH];
    assign smp[0] = gyro_y_rate;
    assign smp[1] = gyro_z_rate;
    assign smp[2] = accel_x;
    assign smp[3] = accel_y;

    // ---------------- Internal sample clock ----------------
    logic [DIV_W-1:0] div_r;      // Cycle count inside one sample
    logic [DIV_W-1:0] div_nxt;
    logic             int_tick_r; // One-cycle pulse per sample
    wire              div_wrap = (div_r == DIV_W'(SAMPLE_DIV - 1));

    assign div_nxt = div_wrap ? '0 : DIV_W'(div_r + 1'b1);

    // Free-running divider from the core clock
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            div_r      <= '0;
            int_tick_r <= 1'b0;
        end else begin
            div_r      <= div_nxt;
            int_tick_r <= div_wrap; // R3
        end
    end

    // External timing replaces the internal rate when selected
    wire run_tick = ext_sample_sel ? ext_sample_tick : int_tick_r;

    // ---------------- Sequencing ----------------
    davi_pkg::davi_state_t st_r;      // Current state
    davi_pkg::davi_state_t st_nxt;
    logic [DEC_W-1:0]      cnt_r;     // Samples taken so far in period
    logic [DEC_W-1:0]      cnt_nxt;
    logic [DEC_W-1:0]      dec_lat_r; // Setting held for this period
    logic [DEC_W-1:0]      dec_nxt;

    // Publish cycle restarts the period, so a tick there counts as
    // the first sample of the next one and is never lost
    wire             pub_now  = (st_r == davi_pkg::ST_PUB);
    wire             priming  = (st_r == davi_pkg::ST_PRIME);
    wire [DEC_W-1:0] base_cnt = pub_now ? '0 : cnt_r;
    wire [DEC_W-1:0] dec_cur  = (pub_now || priming) ? decimation_setting : dec_lat_r;
    wire             acc_tick = run_tick && !priming;
    wire             last_smp = (base_cnt == dec_cur);  // R2

    assign dec_nxt = dec_cur;

    // Next state and sample count
    always_comb begin
        st_nxt  = davi_pkg::ST_RUN;
        cnt_nxt = base_cnt;
        case (st_r)
            davi_pkg::ST_PRIME: begin
                // First sample only fills the previous-sample store
                st_nxt  = run_tick ? davi_pkg::ST_RUN : davi_pkg::ST_PRIME;
                cnt_nxt = '0;
            end
            davi_pkg::ST_RUN, davi_pkg::ST_PUB: begin
                if (acc_tick && last_smp) begin
                    st_nxt  = davi_pkg::ST_PUB; // R2
                    cnt_nxt = '0;
                end else if (acc_tick) begin
                    cnt_nxt = DEC_W'(base_cnt + 1'b1);
                end
            end
            default: begin
                st_nxt  = davi_pkg::ST_PRIME;
                cnt_nxt = '0;
            end
        endcase
    end

    // State registers
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            st_r      <= davi_pkg::ST_PRIME;
            cnt_r     <= '0;
            dec_lat_r <= '0;
        end else begin
            st_r      <= st_nxt;
            cnt_r     <= cnt_nxt;
            dec_lat_r <= dec_nxt;
        end
    end

    // ---------------- Per-channel trapezoid integrators ----------------
    logic signed [SAMPLE_W-1:0] prev_r   [NUM_CH]; // Previous sample
    logic signed [ACC_W-1:0]    acc_r    [NUM_CH]; // Running sum
    logic signed [ACC_W-1:0]    acc_nxt  [NUM_CH];
    logic signed [ACC_W-1:0]    pair_sum [NUM_CH]; // Current plus previous
    logic signed [ACC_W-1:0]    half_acc [NUM_CH]; // Sum times one half
    logic [RES_W-1:0]           res_word [NUM_CH]; // Saturated result
    logic [NUM_CH-1:0]          ovf_hi;            // Above positive limit
    logic [NUM_CH-1:0]          ovf_lo;            // Below negative limit
    logic [2*NUM_CH*WORD_W-1:0] ld_data;           // All eight words

    genvar c;
    for (c = 0; c < NUM_CH; c++) begin : g_ch
        // Gyro and accel channels share this sum
        assign pair_sum[c] = ACC_W'(smp[c]) + ACC_W'(prev_r[c]); // R1 R15
        assign acc_nxt[c]  = (pub_now ? ACC_W'(0) : acc_r[c])
                           + (acc_tick ? pair_sum[c] : ACC_W'(0));
        // The halving; 1/fs is carried by the input LSB weight
        assign half_acc[c] = acc_r[c] >>> davi_pkg::SCALE_SHIFT; // R1 R5 R6 R16
        assign ovf_hi[c]   = !half_acc[c][ACC_W-1] && (|half_acc[c][ACC_W-2:RES_W-1]);
        assign ovf_lo[c]   = half_acc[c][ACC_W-1] && !(&half_acc[c][ACC_W-2:RES_W-1]);
        // Clamp rather than wrap, so a huge motion never flips sign
        assign res_word[c] = ovf_hi[c] ? davi_pkg::RES_MAX :
                             ovf_lo[c] ? davi_pkg::RES_MIN :
                             half_acc[c][RES_W-1:0]; // R13
        // Low word keeps the fine bits, high word the coarse ones
        assign ld_data[(2*c)*WORD_W +: WORD_W]   = res_word[c][WORD_W-1:0];     // R4 R7
        assign ld_data[(2*c+1)*WORD_W +: WORD_W] = res_word[c][RES_W-1:WORD_W]; // R4 R12

        // Accumulator and previous-sample store
        always_ff @(posedge ref_clk) begin
            if (!resetn) begin
                prev_r[c] <= '0;
                acc_r[c]  <= '0;
            end else begin
                if (run_tick) begin
                    prev_r[c] <= smp[c]; // R1 R15
                end
                acc_r[c] <= acc_nxt[c];
            end
        end
    end

    // ---------------- Register read and publish ----------------
    wire [davi_pkg::ADDR_W-1:0] rd_off = davi_pkg::ADDR_W'(rd_addr - davi_pkg::ADDR_Y_ANG_LO);
    // Offset wraps high below the base, so one compare covers both ends
    wire                        rd_hit = (rd_off < davi_pkg::BANK_SPAN); // R8 R9 R10 R11
    wire [davi_pkg::IDX_W-1:0]  rd_idx = rd_off[davi_pkg::IDX_W:1];

    logic rd_valid_r;       // Read answer strobe
    logic result_update_r;  // Publish strobe

    // Strobes follow their cause by one cycle
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rd_valid_r      <= 1'b0;
            result_update_r <= 1'b0;
        end else begin
            rd_valid_r      <= rd_en;
            result_update_r <= pub_now; // R17
        end
    end

    assign rd_valid      = rd_valid_r;
    assign result_update = result_update_r;

    // Word bank loads every axis in the same cycle
    davi_result_bank #(
        .DEPTH  (2 * NUM_CH),
        .WORD_W (WORD_W),
        .IDX_W  (davi_pkg::IDX_W)
    ) u_bank (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .ld_en   (pub_now),
        .ld_data (ld_data),
        .rd_en   (rd_en),
        .rd_hit  (rd_hit),
        .rd_idx  (rd_idx),
        .rd_data (rd_data)
    );

    // ---------------- Checks ----------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    // Samples summed since the last publish
    logic [DEC_W:0]   smp_seen_r;
    // Cycles since the last internal tick
    logic [DIV_W:0]   gap_r;
    logic             tick_seen_r;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            smp_seen_r  <= '0;
            gap_r       <= '0;
            tick_seen_r <= 1'b0;
        end else begin
            smp_seen_r  <= (pub_now ? '0 : smp_seen_r) + (DEC_W+1)'(acc_tick);
            gap_r       <= int_tick_r ? '0 : (DIV_W+1)'(gap_r + 1'b1);
            tick_seen_r <= tick_seen_r || int_tick_r;
        end
    end

    sequence pub_step;
        st_r == davi_pkg::ST_PUB;
    endsequence
    // Strobe rises while both words of an axis already hold the published pair
    sequence upd_step;
        result_update
            && u_bank.mem_r[0] == $past(ld_data[WORD_W-1:0])
            && u_bank.mem_r[1] == $past(ld_data[2*WORD_W-1:WORD_W]);
    endsequence

    dec_count_a: assert property (st_r == davi_pkg::ST_PUB |-> // R2
        smp_seen_r == ({1'b0, dec_lat_r} + 1'b1))
        else $error("sample count per result differs from setting plus one");
    tick_gap_a: assert property (int_tick_r && tick_seen_r |-> // R3
        gap_r == (DIV_W+1)'(SAMPLE_DIV - 1))
        else $error("internal sample tick spacing wrong");
    trap_gyro_a: assert property (st_r == davi_pkg::ST_RUN && acc_tick |=> // R15
        acc_r[0] == $past(acc_r[0]) + $past(pair_sum[0]))
        else $error("gyro sum did not add current plus previous");
    trap_accel_a: assert property (st_r == davi_pkg::ST_PUB && acc_tick |=> // R1
        acc_r[2] == $past(pair_sum[2]))
        else $error("accel sum did not restart from the pair");
    sat_pos_a: assert property (pub_now && ovf_hi[0] |-> // R12
        ld_data[1*WORD_W +: WORD_W] == davi_pkg::RES_MAX[RES_W-1:WORD_W])
        else $error("positive overflow not clamped");
    sat_neg_a: assert property (pub_now && ovf_lo[1] |-> // R13
        {ld_data[3*WORD_W +: WORD_W], ld_data[2*WORD_W +: WORD_W]} == davi_pkg::RES_MIN)
        else $error("negative overflow not clamped");
    pair_load_a: assert property (pub_step |=> upd_step) // R17
        else $error("publish not followed by update strobe");
    miss_zero_a: assert property (rd_en && !rd_hit |=> // R8
        rd_valid && rd_data == davi_pkg::WORD_RESET)
        else $error("unmapped read did not return zero");
    prime_hold_a: assert property (st_r == davi_pkg::ST_PRIME |=> // R1
        acc_r[3] == '0 && !result_update)
        else $error("sum moved before first sample");

endmodule

//--- verification/davi_host_model.sv
// Host-side model: issues register reads and returns the word seen.
// Assumes tasks are called at a falling edge of ref_clk.
`timescale 1ns/100ps
module davi_host_model (
    // Clock
    input  wire logic        ref_clk,
    // Device answer
    input  wire logic        rd_valid,
    input  wire logic [15:0] rd_data,
    // Read request toward the device
    output logic             rd_en,
    output logic [6:0]       rd_addr
);
    // Idle at time zero
    initial begin
        rd_en   = 1'b0;
        rd_addr = 7'h00;
    end

    // One read; request held high across back-to-back reads until last
    task automatic read_word(input logic [6:0] addr, input bit last, output logic [15:0] data, output logic valid);
        rd_en   = 1'b1;
        rd_addr = addr;
        @(negedge ref_clk);
        valid = rd_valid;
        data  = rd_data;
        if (last) begin
            // Released address shows a changed pattern, never the old one
            rd_en   = 1'b0;
            rd_addr = ~addr;
        end
    endtask
endmodule

//--- verification/tb_top.sv
// Self-checking bench for the delta angle and velocity integrator.
// Assumes a short internal divider and a host model on the read port.
`timescale 1ns/100ps
module tb_top;
    localparam int SW  = 24;     // Sample width handed to the design
    localparam int DIV = 8;      // Shortened internal sample divider
    // Design stimulus and observation
    logic                        ref_clk;
    logic                        resetn;
    logic                        ext_sample_sel;
    logic                        ext_sample_tick;
    logic [davi_pkg::DEC_W-1:0]  decimation_setting;
    logic signed [SW-1:0]        smp [4];
    logic                        rd_en;
    logic [davi_pkg::ADDR_W-1:0] rd_addr;
    logic                        rd_valid;
    logic [davi_pkg::WORD_W-1:0] rd_data;
    logic                        result_update;
    // Bench bookkeeping and reference model state
    integer                      seed = 32'h8b93;
    int                          n_mismatch = 0;
    int                          cmp_count = 0;
    int                          n_upd = 0;
    logic signed [SW-1:0]        prev [4];
    longint                      acc [4];
    logic [31:0]                 res [4];
    time                         t0;
    time                         t1;
    int                          dec;
    int                          nd;
    int                          base_upd;

    davi_integrator #(.SAMPLE_W(SW), .SAMPLE_DIV(DIV)) uut (
        .ref_clk(ref_clk), .resetn(resetn), .ext_sample_sel(ext_sample_sel),
        .ext_sample_tick(ext_sample_tick), .decimation_setting(decimation_setting),
        .gyro_y_rate(smp[0]), .gyro_z_rate(smp[1]), .accel_x(smp[2]), .accel_y(smp[3]),
        .rd_en(rd_en), .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data),
        .result_update(result_update));

    davi_host_model host (
        .ref_clk(ref_clk), .rd_valid(rd_valid), .rd_data(rd_data), .rd_en(rd_en), .rd_addr(rd_addr));

    // Free-running 250 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // Count published result sets
    always @(posedge ref_clk) begin
        if (result_update === 1'b1) n_upd++;
    end

    // Halve the trapezoid sum with floor, then clamp to 32 bits
    function automatic logic [31:0] sat_half(input longint s);
        longint h;
        h = s >>> 1;
        if (h > 64'sd2147483647) return 32'h7FFFFFFF;
        if (h < -64'sd2147483648) return 32'h80000000;
        return h[31:0];
    endfunction

    task automatic end_sim();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One sample tick; the reference sums current plus previous sample
    task automatic do_tick(input bit prime);
        repeat (1 + ($random(seed) & 1)) @(negedge ref_clk);
        ext_sample_tick = 1'b1;
        for (int c = 0; c < 4; c++) begin
            if (!prime) acc[c] += longint'(smp[c]) + longint'(prev[c]);
            prev[c] = smp[c];
        end
        @(negedge ref_clk);
        ext_sample_tick = 1'b0;
    endtask

    // Eight result words back to back, odd byte now and then, two unmapped
    task automatic read_all();
        logic [15:0] d;
        logic        v;
        logic [6:0]  a;
        for (int w = 0; w < 10; w++) begin
            a = (w < 8) ? 7'h28 + 7'(2 * w) + 7'($random(seed) & 1) : ((w == 8) ? 7'h38 : 7'h27);
            host.read_word(a, w == 9, d, v);
            chk({31'h0, v}, 32'h1);
            chk({16'h0, d}, (w < 8) ? {16'h0, (w % 2) ? res[w / 2][31:16] : res[w / 2][15:0]} : 32'h0);
        end
    endtask

    // One decimation period of d ticks, then publish and read back
    task automatic period(input int d, input logic [15:0] dec_next, input bit sat);
        int base;
        base = n_upd;
        for (int t = 0; t < d; t++) begin
            for (int c = 0; c < 4; c++) begin
                if (sat) smp[c] = (c == 0) ? 24'h7FFFFF : (c == 1) ? 24'h800000 : (c == 2) ? 24'hFFFFFF : 24'h000001;
                else smp[c] = SW'($random(seed));
            end
            // Next setting is captured at the publish cycle
            if (t == d - 1) decimation_setting = dec_next;
            do_tick(1'b0);
        end
        chk(n_upd, base);
        repeat (4) @(negedge ref_clk);
        chk(n_upd, base + 1);
        for (int c = 0; c < 4; c++) begin
            res[c] = sat_half(acc[c]);
            acc[c] = 0;
        end
        read_all();
    endtask

    // Wait, bounded, for the next published set
    task automatic wait_upd(output time t);
        int base;
        base = n_upd;
        for (int i = 0; i < 4 * DIV && n_upd == base; i++) @(negedge ref_clk);
        t = $time;
    endtask

    // Main sequence
    initial begin
        resetn = 1'b0;
        ext_sample_sel = 1'b1;
        ext_sample_tick = 1'b0;
        decimation_setting = 16'h0000;
        for (int c = 0; c < 4; c++) begin
            smp[c] = 24'h000000;
            prev[c] = 24'h000000;
            acc[c] = 0;
            res[c] = 32'h00000000;
        end
        repeat (20) @(negedge ref_clk);
        resetn = 1'b1;
        read_all();
        // Priming tick only stores the previous sample
        dec = $random(seed) & 3;
        decimation_setting = 16'(dec);
        for (int c = 0; c < 4; c++) smp[c] = SW'($random(seed));
        do_tick(1'b1);
        // Random periods, setting 0 among them, last one sets a long period
        for (int p = 0; p < 30; p++) begin
            nd = (p == 29) ? 299 : ($random(seed) & 7);
            period(dec + 1, 16'(nd), 1'b0);
            dec = nd;
        end
        // Full-scale inputs drive both clamps and the minus-one word
        period(dec + 1, 16'h0000, 1'b1);
        // Back-to-back ticks with setting zero: the second lands in the publish cycle
        base_upd = n_upd;
        @(negedge ref_clk);
        for (int k = 0; k < 2; k++) begin
            for (int c = 0; c < 4; c++) begin
                smp[c] = SW'($random(seed));
                acc[c] = longint'(smp[c]) + longint'(prev[c]);
                prev[c] = smp[c];
            end
            ext_sample_tick = 1'b1;
            @(negedge ref_clk);
        end
        ext_sample_tick = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk(n_upd, base_upd + 2);
        for (int c = 0; c < 4; c++) begin
            res[c] = sat_half(acc[c]);
            acc[c] = 0;
        end
        read_all();
        // Internal tick: one result per sample with setting zero
        ext_sample_sel = 1'b0;
        wait_upd(t0);
        wait_upd(t0);
        wait_upd(t1);
        chk(32'((t1 - t0) / 4), DIV);
        end_sim();
    end

    // Hang guard, well above the expected run length
    initial begin
        #100000;
        n_mismatch++;
        end_sim();
    end
endmodule
